// ==== core/output_module_map.sv ====
// Output module process image, line fault status and watchdog behind an AHB-Lite slave
// How it works
// R1: The allocated coil area starts at zero offset, number 1 in the legacy scheme, written by codes 5 or 15 and read by code 1.
// R2: The allocated word area starts at offset 1280, legacy 46101, packs the output bits in order, written by 6 or 16 and read by 3.
// R3: The slot coil area starts at 1024, legacy 3001, and a bit sits at area start plus eight times slot plus bit number.
// R4: Each output area resolves from a direct offset and from a legacy number to the same storage.
// R5: After three failed exchanges in a row the watchdog switches all outputs off 500 ms later.
// R6: Line fault reporting is enabled per channel and a disabled channel never reports a fault.
// R7: The valve circuit test pulse is brief and a per-channel bit can suppress it.
// R8: Each channel shows a read-only type code for binary input, binary output, analog input or analog output.
// R9: The status byte alternates channel status and fault flag from bit 0 for channels 1 to 3, fault reading 1.
// R10: In the output byte bit 0 is the valve value and bit 1 marks the data invalid when set.
// R11: On watchdog expiry or invalid data the output follows the chosen current, substitute or last valid behaviour; here expiry forces the valve off.
// R12: A request outside every output area is answered with an illegal data address exception.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "output_module_params.svh"
module output_module_map
  import output_module_pkg::*;
#(
  parameter int unsigned WD_TIMEOUT_CYC = `WD_TIMEOUT_CYC,
  parameter logic [7:0]  SLOT           = `SLOT_DEFAULT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  fb_in,
  input  wire logic [2:0]  lf_in,
  input  wire logic        comm_ok,
  input  wire logic        comm_fail,
  output logic             valve_out,
  output logic             test_pulse,
  output logic             wd_tripped
);

  localparam logic [5:0]  TYPE_WORD = {binary_input_channel, binary_input_channel,
                                       binary_output_channel};
  localparam logic [15:0] SLOT_LO   = `COIL_SLOT_DIRECT + {5'h00, SLOT, 3'h0};

  top_s        r_reg;
  top_s        r_next;
  logic        trip;
  logic        addr_ok;
  logic [15:0] dir;
  logic [15:0] slot_off;
  logic [15:0] bit_idx;
  req_s        req_in;
  logic        is_coil;
  logic        is_hold;
  logic        err;
  logic        acc_rd;
  logic        acc_wr;

  comm_watchdog #(
    .TIMEOUT_CYC (WD_TIMEOUT_CYC)
  ) u_wd (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .comm_ok   (comm_ok),
    .comm_fail (comm_fail),
    .tripped   (trip)
  );

  // Register read mux; unmapped words read as zero
  function automatic logic [31:0] reg_read(input top_s s, input logic [31:0] a, input logic t);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[31:8] == 24'h00_0000) begin
      case (a[7:0])
        `OFF_REQ:    v = s.req;
        `OFF_WDATA:  v = {16'h0000, s.wdata};
        `OFF_RESP:   v = s.resp;
        `OFF_CFG:    v = {25'h000_0000, s.cfg};
        `OFF_STATUS: v = {22'h00_0000, t, s.valve, s.stat};
        // R8: fixed channel types
        `OFF_TYPE:   v = {26'h000_0000, TYPE_WORD};
        default:     v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  // Word transfers only; other sizes are accepted and ignored
  assign acc_rd = hsel && htrans[1] && hready && !hwrite && (hsize == 3'h2);
  assign acc_wr = hsel && htrans[1] && hready && hwrite && (hsize == 3'h2)
                  && (haddr[31:8] == 24'h00_0000);
  assign req_in = hwdata;
  assign is_coil = (req_in.func == `FC_READ_COILS) || (req_in.func == `FC_WRITE_COIL)
                   || (req_in.func == `FC_WRITE_COILS);
  assign is_hold = (req_in.func == `FC_READ_HOLD) || (req_in.func == `FC_WRITE_HOLD)
                   || (req_in.func == `FC_WRITE_HOLDS);

  // R4: both numbering schemes land on one direct offset
  always_comb begin
    addr_ok = 1'b1;
    dir     = req_in.addr;
    if (req_in.scheme == legacy_numbering_scheme) begin
      if (is_coil && req_in.addr >= `COIL_SLOT_LEGACY) begin
        dir = req_in.addr - `COIL_SLOT_LEGACY + `COIL_SLOT_DIRECT;
      end else if (is_coil && req_in.addr >= `COIL_ALLOC_LEGACY) begin
        dir = req_in.addr - `COIL_ALLOC_LEGACY + `COIL_ALLOC_DIRECT;
      end else if (is_hold && req_in.addr >= `HOLD_LEGACY) begin
        dir = req_in.addr - `HOLD_LEGACY + `HOLD_DIRECT;
      end else begin
        addr_ok = 1'b0;
      end
    end
    slot_off = dir - SLOT_LO;
  end

  // Invalid marker in the output byte drives the fallback path
  assign err = r_reg.out_byte[1];

  // Next-state logic of the whole block; bit index defaults to the slot area position
  always_comb begin
    r_next  = r_reg;
    bit_idx = slot_off;
    // Three-stage input filter; a change is taken once stages two and three agree
    r_next.sync1 = {lf_in, fb_in};
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    r_next.filt  = (r_reg.sync2 & r_reg.sync3) | (r_reg.filt & (r_reg.sync2 | r_reg.sync3));

    // R9: status and masked faults in pairs
    // R6: disabled channel shows no fault
    r_next.stat = {2'h0, r_reg.filt[4] & r_reg.cfg.lf_en[2], r_reg.filt[1],
                   r_reg.filt[3] & r_reg.cfg.lf_en[1], r_reg.filt[0],
                   r_reg.filt[2] & r_reg.cfg.lf_en[0], r_reg.valve};

    // R5: tripped watchdog forces off
    // R11: fallback per error mode
    if (trip) begin
      r_next.valve = 1'b0;
    end else if (err) begin
      case (r_reg.cfg.mode)
        mode_substitute: r_next.valve = r_reg.cfg.subst_val;
        mode_last_valid: r_next.valve = r_reg.last_valid;
        default:         r_next.valve = r_reg.out_byte[0];
      endcase
    end else begin
      r_next.valve      = r_reg.out_byte[0];
      r_next.last_valid = r_reg.out_byte[0];
    end

    // R7: periodic one-cycle test pulse, suppressible
    r_next.tp_cnt = (r_reg.tp_cnt == `TEST_PERIOD_CYC - 16'h0001) ? 16'h0000
                    : r_reg.tp_cnt + 16'h0001;
    r_next.tpulse = r_reg.cfg.tp_en && (r_reg.tp_cnt == `TEST_PERIOD_CYC - 16'h0001);

    // Bus address phase; zero wait states, always OKAY
    r_next.hready  = 1'b1;
    r_next.wr_pend = acc_wr;
    if (acc_wr) begin
      r_next.wr_addr = haddr[7:0];
    end
    if (acc_rd) begin
      r_next.hrdata = reg_read(r_reg, haddr, trip);
    end

    // Bus data phase writes
    if (r_reg.wr_pend) begin
      case (r_reg.wr_addr)
        `OFF_WDATA: r_next.wdata = hwdata[15:0];
        `OFF_CFG:   r_next.cfg   = hwdata[6:0];
        `OFF_REQ: begin
          r_next.req       = req_in;
          r_next.resp      = '0;
          r_next.resp.done = 1'b1;
          if (is_coil) begin
            // R1: allocated coils
            // R3: slot coils
            if (addr_ok && dir < `COIL_ALLOC_DIRECT + `COIL_ALLOC_COUNT) begin
              bit_idx = dir - `COIL_ALLOC_DIRECT;
            end else if (!(addr_ok && dir >= SLOT_LO && slot_off < `COIL_SLOT_BITS)) begin
              // R12: outside every coil area
              r_next.resp.exc = `EXC_ADDRESS;
            end
            if (r_next.resp.exc == `EXC_NONE) begin
              if (req_in.func == `FC_READ_COILS) begin
                r_next.resp.data = (bit_idx < 16'h0002)
                                   ? {15'h0000, r_reg.out_byte[bit_idx[0]]} : 16'h0000;
              end else if (req_in.func == `FC_WRITE_COIL && r_reg.wdata != `COIL_ON_WORD
                           && r_reg.wdata != `COIL_OFF_WORD) begin
                r_next.resp.exc = `EXC_VALUE;
              end else if (bit_idx < 16'h0002) begin
                // R10: bit 0 value, bit 1 invalid marker
                r_next.out_byte[bit_idx[0]] = (req_in.func == `FC_WRITE_COIL)
                                               ? r_reg.wdata[8] : r_reg.wdata[0];
              end
            end
          end else if (is_hold) begin
            // R2: packed output word
            if (!(addr_ok && dir == `HOLD_DIRECT)) begin
              // R12: outside the word area
              r_next.resp.exc = `EXC_ADDRESS;
            end else if (req_in.func == `FC_READ_HOLD) begin
              r_next.resp.data = {14'h0000, r_reg.out_byte};
            end else begin
              r_next.out_byte = r_reg.wdata[1:0];
            end
          end else begin
            r_next.resp.exc = `EXC_FUNCTION;
          end
        end
        default: r_next.wdata = r_reg.wdata;
      endcase
    end
  end

  // State register; configuration comes up with all monitoring enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg        <= '0;
      r_reg.cfg    <= `CFG_RESET;
      r_reg.hready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata     = r_reg.hrdata;
  assign hreadyout  = r_reg.hready;
  assign hresp      = 1'b0;
  assign valve_out  = r_reg.valve;
  assign test_pulse = r_reg.tpulse;
  assign wd_tripped = trip;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence req_exec;
    r_reg.wr_pend && r_reg.wr_addr == `OFF_REQ;
  endsequence
  sequence legacy_coil_on;
    req_exec ##0 req_in.func == `FC_WRITE_COIL && req_in.scheme == legacy_numbering_scheme
      && req_in.addr == `COIL_ALLOC_LEGACY && r_reg.wdata == `COIL_ON_WORD;
  endsequence

  AST_OFF_WHEN_TRIPPED: assert property (trip |=> !valve_out) // R5
    else $error("valve on while watchdog tripped");
  AST_FAULT_MASKED: assert property (r_reg.stat[1] |-> $past(r_reg.cfg.lf_en[0])) // R6
    else $error("fault shown on disabled channel");
  AST_PULSE_SUPPRESSED: assert property (test_pulse |->  // R7
      $past(r_reg.cfg.tp_en) ##1 !test_pulse)
    else $error("test pulse while disabled or too long");
  AST_TYPE_READ: assert property (acc_rd && haddr == 32'h0000_0014  // R8
      |=> hrdata == 32'h0000_0001)
    else $error("type word wrong");
  AST_STATUS_LAYOUT: assert property (##1 r_reg.stat[7:6] == 2'h0  // R9
      && r_reg.stat[0] == $past(r_reg.valve))
    else $error("status byte layout broken");
  AST_SUBSTITUTE: assert property (err && !trip && r_reg.cfg.mode == mode_substitute  // R11
      |=> valve_out == $past(r_reg.cfg.subst_val))
    else $error("substitute value not applied");
  AST_REJECT_KEEPS: assert property (req_exec ##1 r_reg.resp.exc == `EXC_ADDRESS  // R12
      |-> $stable(r_reg.out_byte) && r_reg.resp.done)
    else $error("rejected access changed storage");
  AST_LEGACY_SAME: assert property (legacy_coil_on  // R4
      |=> r_reg.out_byte[0] && r_reg.resp.exc == 8'h00)
    else $error("legacy number 1 did not reach coil 0");

endmodule

// ==== core/output_module_params.svh ====
// Offsets, protocol numbers, reset values and timing counts of the output module map
`ifndef OUTPUT_MODULE_PARAMS_SVH
`define OUTPUT_MODULE_PARAMS_SVH

// Bus register byte offsets
`define OFF_REQ           8'h00
`define OFF_WDATA         8'h04
`define OFF_RESP          8'h08
`define OFF_CFG           8'h0C
`define OFF_STATUS        8'h10
`define OFF_TYPE          8'h14

// Output areas, zero-based offsets and one-based numbers
`define COIL_ALLOC_DIRECT 16'h0000
`define COIL_ALLOC_LEGACY 16'h0001
`define COIL_ALLOC_COUNT  16'h0002
`define COIL_SLOT_DIRECT  16'h0400
`define COIL_SLOT_LEGACY  16'h0BB9
`define COIL_SLOT_BITS    16'h0008
`define HOLD_DIRECT       16'h0500
`define HOLD_LEGACY       16'hB415

// Function codes and exception codes
`define FC_READ_COILS     8'h01
`define FC_WRITE_COIL     8'h05
`define FC_WRITE_COILS    8'h0F
`define FC_READ_HOLD      8'h03
`define FC_WRITE_HOLD     8'h06
`define FC_WRITE_HOLDS    8'h10
`define EXC_NONE          8'h00
`define EXC_FUNCTION      8'h01
`define EXC_ADDRESS       8'h02
`define EXC_VALUE         8'h03
`define COIL_ON_WORD      16'hFF00
`define COIL_OFF_WORD     16'h0000

// Reset values
`define CFG_RESET         7'h0F
`define SLOT_DEFAULT      8'h01

// Timing
`define CLK_FREQ_HZ       10000000
`define WD_TIMEOUT_MS     500
`define WD_TIMEOUT_CYC    (`WD_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000))
`define WD_FAIL_LIMIT     2'h3
`define TEST_PERIOD_CYC   16'h0FA0

`endif

// ==== core/output_module_pkg.sv ====
// Types shared by the output module map and its watchdog
package output_module_pkg;

  typedef enum logic [1:0] {mode_current, mode_substitute, mode_last_valid} err_mode_e;
  typedef enum logic [1:0] {binary_input_channel, binary_output_channel,
                            analog_input_channel, analog_output_channel} chan_type_e;
  typedef enum logic {direct_offset_scheme, legacy_numbering_scheme} addr_scheme_e;
  typedef enum logic [1:0] {wd_counting, wd_waiting, wd_tripped} wd_state_e;

  typedef struct packed {
    logic       subst_val;
    err_mode_e  mode;
    logic       tp_en;
    logic [2:0] lf_en;
  } cfg_s;

  typedef struct packed {
    logic [15:0]  addr;
    logic [6:0]   spare;
    addr_scheme_e scheme;
    logic [7:0]   func;
  } req_s;

  typedef struct packed {
    logic [6:0]  spare;
    logic        done;
    logic [7:0]  exc;
    logic [15:0] data;
  } resp_s;

  typedef struct packed {
    wd_state_e   st;
    logic [1:0]  fails;
    logic [22:0] timer;
    logic        trip;
  } wd_s;

  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  sync3;
    logic [4:0]  filt;
    cfg_s        cfg;
    req_s        req;
    logic [15:0] wdata;
    resp_s       resp;
    logic [1:0]  out_byte;
    logic        last_valid;
    logic        valve;
    logic        tpulse;
    logic [15:0] tp_cnt;
    logic [7:0]  stat;
    logic [31:0] hrdata;
    logic        hready;
    logic        wr_pend;
    logic [7:0]  wr_addr;
  } top_s;

endpackage

// ==== core/comm_watchdog.sv ====
// Communication watchdog: trips after three failed attempts and a timeout
`timescale 1ns/1ps
`include "output_module_params.svh"
module comm_watchdog
  import output_module_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `WD_TIMEOUT_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic comm_ok,
  input  wire logic comm_fail,
  output logic      tripped
);

  wd_s r_reg;
  wd_s r_next;

  // Fail counting, then timeout; a good exchange always rearms
  always_comb begin
    r_next = r_reg;
    unique case (r_reg.st)
      wd_counting: begin
        if (comm_ok) begin
          r_next.fails = 2'h0;
        end else if (comm_fail) begin
          // R5: third failure starts timer
          if (r_reg.fails == `WD_FAIL_LIMIT - 2'h1) begin
            r_next.st    = wd_waiting;
            r_next.fails = 2'h0;
            r_next.timer = 23'h0;
          end else begin
            r_next.fails = r_reg.fails + 2'h1;
          end
        end
      end
      wd_waiting: begin
        if (comm_ok) begin
          r_next.st = wd_counting;
        end else if (r_reg.timer == 23'(TIMEOUT_CYC - 1)) begin
          // R5: timeout switches off
          r_next.st   = wd_tripped;
          r_next.trip = 1'b1;
        end else begin
          r_next.timer = r_reg.timer + 23'h1;
        end
      end
      wd_tripped: begin
        if (comm_ok) begin
          r_next.st   = wd_counting;
          r_next.trip = 1'b0;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tripped = r_reg.trip;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence third_fail;
    r_reg.st == wd_counting && r_reg.fails == 2'h2 && comm_fail && !comm_ok;
  endsequence

  AST_THIRD_FAIL_ARMS: assert property (third_fail |=> r_reg.st == wd_waiting && !r_reg.trip) // R5
    else $error("third failure did not start the timeout");
  AST_TIMEOUT_TRIPS: assert property (r_reg.st == wd_waiting && !comm_ok &&  // R5
      r_reg.timer == 23'(TIMEOUT_CYC - 1) |=> r_reg.trip)
    else $error("watchdog did not trip at timeout");
  AST_NO_EARLY_TRIP: assert property ($rose(r_reg.trip) |->  // R5
      $past(r_reg.st) == wd_waiting && $past(r_reg.timer) == 23'(TIMEOUT_CYC - 1))
    else $error("watchdog tripped early");

endmodule

// ==== verif/com_unit_model.sv ====
// Com unit stand-in that reports the outcome of each exchange to the watchdog
`timescale 1ns/1ps
module com_unit_model (
  input  wire logic hclk,
  output logic      comm_ok,
  output logic      comm_fail
);
  // Both outcome lines idle low outside an exchange
  initial begin
    comm_ok   = 1'b0;
    comm_fail = 1'b0;
  end

  // One exchange is a single-cycle pulse; a gap cycle follows so pulses never merge
  task automatic exchange(input logic ok);
    comm_ok   <= ok;
    comm_fail <= !ok;
    @(posedge hclk);
    comm_ok   <= 1'b0;
    comm_fail <= 1'b0;
    @(posedge hclk);
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the output module map over AHB-Lite
`timescale 1ns/1ps
`include "output_module_params.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb;
  import output_module_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  fb_in;
  logic [2:0]  lf_in;
  logic        comm_ok;
  logic        comm_fail;
  logic        valve_out;
  logic        test_pulse;
  logic        wd_tripped;
  int          fail_count;
  int          checks_done;
  int          cycles;
  int          cnt;
  logic [31:0] q_sub;
  logic [6:0]  mode_cfg [5] = '{7'h0F, 7'h1F, 7'h5F, 7'h2F, 7'h3F};
  logic        mode_exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  // Short watchdog timeout keeps the run brief; the slot stays at its default
  output_module_map #(.WD_TIMEOUT_CYC(20)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fb_in(fb_in),
    .lf_in(lf_in), .comm_ok(comm_ok), .comm_fail(comm_fail), .valve_out(valve_out),
    .test_pulse(test_pulse), .wd_tripped(wd_tripped));

  com_unit_model com (.hclk(hclk), .comm_ok(comm_ok), .comm_fail(comm_fail));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Hang guard: the tests need about 8300 cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH run_length expected %h seen %h", 20000, cycles);
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Waits for hready sampled high; only the hang guard ends a stuck wait
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask

  // Feedback and line fault pins change together, right after an edge
  task automatic pins(input logic [2:0] lf, input logic [1:0] fb);
    lf_in <= lf;
    fb_in <= fb;
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [2:0] sz, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsize  <= sz;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, 3'b010, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    bus(1'b0, 3'b010, a, 32'h0, q);
    `CHK(nm, ex, q)
  endtask

  // Issues one request and checks the response; the idle cycle avoids reading stale RESP
  task automatic mb(input logic [7:0] fc, input addr_scheme_e s, input logic [15:0] ad,
                    input logic [15:0] wd, input logic [7:0] ex, input logic [15:0] dat);
    logic [31:0] q;
    wr(`OFF_WDATA, {16'h0, wd});
    wr(`OFF_REQ, {ad, 7'h0, s, fc});
    @(posedge hclk);
    bus(1'b0, 3'b010, `OFF_RESP, 32'h0, q);
    `CHK("resp_exc", {1'b1, ex}, q[24:16])
    if (ex == 8'h00 && (fc == `FC_READ_COILS || fc == `FC_READ_HOLD)) begin
      `CHK("resp_data", dat, q[15:0])
    end
  endtask

  task automatic vchk(input logic ex);
    repeat (2) @(posedge hclk);
    `CHK("valve_out", ex, valve_out)
  endtask

  // One settling edge first, so a pulse launched under the old enable is not counted
  task automatic count_pulses();
    cnt = 0;
    @(posedge hclk);
    repeat (int'(`TEST_PERIOD_CYC)) begin
      @(posedge hclk);
      if (test_pulse === 1'b1) cnt++;
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0000_0000;
    pins(3'b000, 2'b00);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("cfg", `OFF_CFG, 32'h0000_000F);
    bus(1'b1, 3'b000, `OFF_CFG, 32'h0000_0000, q_sub);
    rdc("cfg_byte_ignored", `OFF_CFG, 32'h0000_000F);
    rdc("type", `OFF_TYPE, 32'h0000_0001);
    wr(`OFF_TYPE, 32'h0000_00FF);
    rdc("type_ro", `OFF_TYPE, 32'h0000_0001);
    wr(8'h20, 32'h0000_FFFF);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    rdc("status", `OFF_STATUS, 32'h0000_0000);
    $display("test reset done");
    mb(`FC_WRITE_COIL, legacy_numbering_scheme, 16'h0001, 16'hFF00, 8'h00, 16'h0);
    vchk(1'b1);
    mb(`FC_READ_COILS, direct_offset_scheme, 16'h0000, 16'h0, 8'h00, 16'h1);
    mb(`FC_READ_COILS, direct_offset_scheme, 16'h0408, 16'h0, 8'h00, 16'h1);
    mb(`FC_WRITE_COILS, legacy_numbering_scheme, 16'h0BC1, 16'h0, 8'h00, 16'h0);
    vchk(1'b0);
    mb(`FC_READ_HOLD, legacy_numbering_scheme, 16'hB415, 16'h0, 8'h00, 16'h0);
    mb(`FC_WRITE_HOLDS, direct_offset_scheme, 16'h0500, 16'h1, 8'h00, 16'h0);
    vchk(1'b1);
    mb(`FC_READ_COILS, legacy_numbering_scheme, 16'h0BC1, 16'h0, 8'h00, 16'h1);
    mb(`FC_READ_COILS, direct_offset_scheme, 16'h040A, 16'h0, 8'h00, 16'h0);
    mb(`FC_WRITE_COIL, direct_offset_scheme, 16'h0000, 16'h1234, `EXC_VALUE, 16'h0);
    mb(`FC_READ_COILS, direct_offset_scheme, 16'h0002, 16'h0, `EXC_ADDRESS, 16'h0);
    mb(`FC_READ_COILS, legacy_numbering_scheme, 16'h0000, 16'h0, `EXC_ADDRESS, 16'h0);
    mb(8'h02, direct_offset_scheme, 16'h0000, 16'h0, `EXC_FUNCTION, 16'h0);
    $display("test addressing done");
    // Last valid value is 0, then an invalid word carrying value 1
    mb(`FC_WRITE_HOLD, direct_offset_scheme, 16'h0500, 16'h0, 8'h00, 16'h0);
    mb(`FC_WRITE_HOLD, direct_offset_scheme, 16'h0500, 16'h3, 8'h00, 16'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_CFG, {25'h0, mode_cfg[i]});
      vchk(mode_exp[i]);
    end
    wr(`OFF_CFG, 32'h0000_000F);
    mb(`FC_WRITE_HOLD, direct_offset_scheme, 16'h0500, 16'h1, 8'h00, 16'h0);
    vchk(1'b1);
    $display("test error modes done");
    pins(3'b111, 2'b11);
    repeat (8) @(posedge hclk);
    rdc("status_all", `OFF_STATUS, 32'h0000_013F);
    wr(`OFF_CFG, 32'h0000_000A);
    repeat (3) @(posedge hclk);
    rdc("status_ch2", `OFF_STATUS, 32'h0000_011D);
    pins(3'b000, 2'b11);
    $display("test status done");
    wr(`OFF_CFG, 32'h0000_000F);
    count_pulses();
    `CHK("pulses_on", 1, cnt)
    wr(`OFF_CFG, 32'h0000_0007);
    count_pulses();
    `CHK("pulses_off", 0, cnt)
    $display("test pulse done");
    com.exchange(1'b0);
    com.exchange(1'b0);
    com.exchange(1'b1);
    com.exchange(1'b0);
    com.exchange(1'b0);
    repeat (40) @(posedge hclk);
    `CHK("no_trip", 1'b0, wd_tripped)
    com.exchange(1'b0);
    cnt = 0;
    while (wd_tripped !== 1'b1 && cnt < 40) begin
      @(posedge hclk);
      cnt++;
    end
    `CHK("trip_delay", 1'b1, cnt >= 17 && cnt <= 24)
    vchk(1'b0);
    rdc("status_trip", `OFF_STATUS, 32'h0000_0214);
    com.exchange(1'b1);
    `CHK("trip_clear", 1'b0, wd_tripped)
    $display("test watchdog done");
    conclude();
  end
endmodule
